// ---- rtl/window_geometry_params.svh ----
`ifndef WINDOW_GEOMETRY_PARAMS_SVH
`define WINDOW_GEOMETRY_PARAMS_SVH
// register offsets on the serial control port
`define ROW_DEPTH_HIGH_ADDR   8'h47
`define ROW_DEPTH_LOW_ADDR    8'h48
`define START_COL_HIGH_ADDR   8'h49
`define START_COL_LOW_ADDR    8'h4a
`define COL_WIDTH_HIGH_ADDR   8'h4b
`define COL_WIDTH_LOW_ADDR    8'h4c
// reset values (undefined ones chosen as zero)
`define HIGH_BYTE_RESET       3'h0
`define LOW_BYTE_RESET        8'h00
// field layout
`define HIGH_FIELD_MSB        2
`define GEOM_WIDTH            11
`define GEOM_ONE              12'h001
`define UNMAPPED_READ         8'h00
`define NUM_GEOM_REGS         6
`endif

// ---- rtl/window_geometry_pkg.sv ----
package window_geometry_pkg;
  // one write or read request on the register port
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // assembled readout window geometry
  typedef struct packed {
    logic [10:0] start_col;
    logic [10:0] row_depth;
    logic [10:0] col_width;
    logic [11:0] row_count;
    logic [11:0] col_count;
  } geom_type;
endpackage : window_geometry_pkg

// ---- rtl/geom_reg_store.sv ----
`timescale 1ns/10ps
`include "window_geometry_params.svh"
// six byte registers of geometry, read data registered
module geom_reg_store (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // write and read select
  input  wire logic [5:0]  wr_sel,
  input  wire logic [5:0]  rd_sel,
  input  wire logic [7:0]  wdata,
  // contents
  output logic      [7:0]  regs_ff [`NUM_GEOM_REGS],
  output logic      [7:0]  rdata_ff
);
  logic [7:0] nxt_regs [`NUM_GEOM_REGS];
  logic [7:0] nxt_rdata;

  // next contents; even slots are high bytes keeping three bits
  always_comb begin
    nxt_rdata = `UNMAPPED_READ;
    for (int i = 0; i < `NUM_GEOM_REGS; i++) begin
      nxt_regs[i] = regs_ff[i];
      if (wr_sel[i]) begin
        if (i % 2 == 0) begin
          nxt_regs[i] = {5'h00, wdata[`HIGH_FIELD_MSB:0]};
        end else begin
          nxt_regs[i] = wdata;
        end
      end
      if (rd_sel[i]) begin
        nxt_rdata = regs_ff[i];
      end
    end
  end

  // register storage
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int i = 0; i < `NUM_GEOM_REGS; i++) begin
        regs_ff[i] <= `LOW_BYTE_RESET;
      end
      rdata_ff <= `UNMAPPED_READ;
    end else begin
      regs_ff  <= nxt_regs;
      rdata_ff <= nxt_rdata;
    end
  end
endmodule : geom_reg_store

// ---- rtl/window_geometry_registers.sv ----
`timescale 1ns/10ps
`include "window_geometry_params.svh"
module window_geometry_registers (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  // register port from serial control
  input  wire window_geometry_pkg::reg_req_type req,
  output logic      [7:0]                    rdata_ff,
  output logic                               rvalid_ff,
  // geometry to the address sequencer
  output window_geometry_pkg::geom_type      geom_ff
);
  logic [5:0] wr_sel;
  logic [5:0] rd_sel;
  logic [7:0] regs [`NUM_GEOM_REGS];
  logic       nxt_rvalid;
  window_geometry_pkg::geom_type nxt_geom;

  // reset geometry: zero fields, so one row and one column
  localparam window_geometry_pkg::geom_type GEOM_RESET = '{
    start_col: '0,
    row_depth: '0,
    col_width: '0,
    row_count: `GEOM_ONE,
    col_count: `GEOM_ONE
  };

  // high field bits 2..0 above the low byte; bits 7..3 never used
  function automatic logic [`GEOM_WIDTH-1:0] join_field(input logic [7:0] hi,
                                                         input logic [7:0] lo);
    join_field = {hi[`HIGH_FIELD_MSB:0], lo};
  endfunction : join_field

  // offset to slot: 0/1 row depth, 2/3 start col, 4/5 col width
  function automatic logic [5:0] decode(input logic [7:0] a);
    case (a)
      `ROW_DEPTH_HIGH_ADDR: decode = 6'h01;
      `ROW_DEPTH_LOW_ADDR:  decode = 6'h02;
      `START_COL_HIGH_ADDR: decode = 6'h04;
      `START_COL_LOW_ADDR:  decode = 6'h08;
      `COL_WIDTH_HIGH_ADDR: decode = 6'h10;
      `COL_WIDTH_LOW_ADDR:  decode = 6'h20;
      default:              decode = 6'h00;
    endcase
  endfunction : decode

  // request decode
  always_comb begin
    wr_sel     = req.wr_en ? decode(req.addr) : 6'h00;
    rd_sel     = req.rd_en ? decode(req.addr) : 6'h00;
    nxt_rvalid = req.rd_en;
  end

  geom_reg_store u_store (
    .clock   (clock),
    .reset_n (reset_n),
    .wr_sel  (wr_sel),
    .rd_sel  (rd_sel),
    .wdata   (req.wdata),
    .regs_ff (regs),
    .rdata_ff(rdata_ff)
  );

  // assemble geometry; row and column counts are depth and width plus one
  always_comb begin
    nxt_geom.row_depth = join_field(regs[0], regs[1]);
    nxt_geom.start_col = join_field(regs[2], regs[3]);
    nxt_geom.col_width = join_field(regs[4], regs[5]);
    nxt_geom.row_count = {1'b0, nxt_geom.row_depth} + `GEOM_ONE;
    nxt_geom.col_count = {1'b0, nxt_geom.col_width} + `GEOM_ONE;
  end

  // output registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      geom_ff   <= GEOM_RESET;
      rvalid_ff <= 1'b0;
    end else begin
      geom_ff   <= nxt_geom;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // row depth low byte lands one edge after the taking edge, checked at the second
  chk_row_assembly: assert property (
    @(posedge clock) disable iff (!reset_n)
    req.wr_en && req.addr == `ROW_DEPTH_LOW_ADDR
    |-> ##2 geom_ff.row_depth[7:0] == $past(req.wdata, 2))
    else $error("row depth low byte not assembled");

  // row depth high bits
  chk_row_high_bits: assert property (
    @(posedge clock) disable iff (!reset_n)
    req.wr_en && req.addr == `ROW_DEPTH_HIGH_ADDR
    |-> ##2 geom_ff.row_depth[10:8] == $past(req.wdata[`HIGH_FIELD_MSB:0], 2))
    else $error("row depth high bits wrong");

  // row count is the depth field plus one
  chk_row_count: assert property (
    @(posedge clock) disable iff (!reset_n)
    geom_ff.row_count == {1'b0, geom_ff.row_depth} + `GEOM_ONE)
    else $error("row count not depth plus one");

  // start column high bits, left edge of the window
  chk_col_assembly: assert property (
    @(posedge clock) disable iff (!reset_n)
    req.wr_en && req.addr == `START_COL_HIGH_ADDR
    |-> ##2 geom_ff.start_col[10:8] == $past(req.wdata[`HIGH_FIELD_MSB:0], 2))
    else $error("start column high bits wrong");

  // start column low byte
  chk_col_low_byte: assert property (
    @(posedge clock) disable iff (!reset_n)
    req.wr_en && req.addr == `START_COL_LOW_ADDR
    |-> ##2 geom_ff.start_col[7:0] == $past(req.wdata, 2))
    else $error("start column low byte wrong");

  // column width low byte
  chk_width_assembly: assert property (
    @(posedge clock) disable iff (!reset_n)
    req.wr_en && req.addr == `COL_WIDTH_LOW_ADDR
    |-> ##2 geom_ff.col_width[7:0] == $past(req.wdata, 2))
    else $error("column width low byte wrong");

  // column width high bits
  chk_width_high_bits: assert property (
    @(posedge clock) disable iff (!reset_n)
    req.wr_en && req.addr == `COL_WIDTH_HIGH_ADDR
    |-> ##2 geom_ff.col_width[10:8] == $past(req.wdata[`HIGH_FIELD_MSB:0], 2))
    else $error("column width high bits wrong");

  // column count is the width field plus one
  chk_col_count: assert property (
    @(posedge clock) disable iff (!reset_n)
    geom_ff.col_count == {1'b0, geom_ff.col_width} + `GEOM_ONE)
    else $error("column count not width plus one");

  // write then read of a high byte returns zeros above bit 2
  chk_high_unused: assert property (
    @(posedge clock) disable iff (!reset_n)
    req.wr_en && req.addr == `ROW_DEPTH_HIGH_ADDR ##1
    req.rd_en && req.addr == `ROW_DEPTH_HIGH_ADDR
    |-> ##1 rdata_ff[7:3] == 5'h00)
    else $error("unused high bits stored");

  // per register pair: high byte drops bits 7..3, low byte keeps all
  for (genvar g = 0; g < `NUM_GEOM_REGS; g = g + 2) begin : gen_pair_chk
    chk_high_store: assert property (
      @(posedge clock) disable iff (!reset_n)
      wr_sel[g] |=> regs[g][7:3] == 5'h00)
      else $error("high byte kept unused bits");
    chk_low_store: assert property (
      @(posedge clock) disable iff (!reset_n)
      wr_sel[g+1] |=> regs[g+1] == $past(req.wdata))
      else $error("low byte not stored");
  end

  // every slot reads back what it held, and holds without a write
  for (genvar s = 0; s < `NUM_GEOM_REGS; s++) begin : gen_slot_chk
    chk_slot_read: assert property (
      @(posedge clock) disable iff (!reset_n)
      rd_sel[s] |=> rdata_ff == $past(regs[s]))
      else $error("read data not slot contents");
    chk_slot_hold: assert property (
      @(posedge clock) disable iff (!reset_n)
      !wr_sel[s] |=> regs[s] == $past(regs[s]))
      else $error("slot changed without a write");
  end

  // read answer comes one cycle after the request
  chk_read_valid: assert property (
    @(posedge clock) disable iff (!reset_n)
    req.rd_en |=> rvalid_ff)
    else $error("read answer missing");

  // no answer without a read
  chk_rvalid_pulse: assert property (
    @(posedge clock) disable iff (!reset_n)
    !req.rd_en |=> !rvalid_ff)
    else $error("read answer without request");

  // unmapped offsets read as zero
  chk_unmapped_read: assert property (
    @(posedge clock) disable iff (!reset_n)
    req.rd_en && decode(req.addr) == 6'h00 |=> rdata_ff == `UNMAPPED_READ)
    else $error("unmapped read not zero");

  // geometry only moves after a mapped write
  chk_geom_hold: assert property (
    @(posedge clock) disable iff (!reset_n)
    wr_sel == 6'h00 |-> ##2 geom_ff == $past(geom_ff))
    else $error("geometry moved without a write");

  // reset clears the answer and leaves a one by one window
  chk_reset_clear: assert property (
    @(posedge clock)
    !reset_n |=> !rvalid_ff && rdata_ff == `UNMAPPED_READ && geom_ff == GEOM_RESET)
    else $error("outputs not cleared by reset");

  // main scenarios
  cov_row_write: cover property (@(posedge clock) req.wr_en && req.addr == `ROW_DEPTH_LOW_ADDR);
  cov_col_write: cover property (@(posedge clock) req.wr_en && req.addr == `START_COL_HIGH_ADDR);
  cov_width_max: cover property (@(posedge clock) geom_ff.col_width == 11'h50f);
  cov_read_back: cover property (@(posedge clock) rvalid_ff);
  cov_junk_bits: cover property (@(posedge clock)
    req.wr_en && req.addr == `ROW_DEPTH_HIGH_ADDR && req.wdata[7:3] != 5'h00);
endmodule : window_geometry_registers

// ---- dv/tb_window_geometry_registers.sv ----
`timescale 1ns/10ps
module tb_window_geometry_registers;
  logic                             clock;
  logic                             reset_n;
  window_geometry_pkg::reg_req_type req;
  logic [7:0]                       rdata_ff;
  logic                             rvalid_ff;
  window_geometry_pkg::geom_type    geom_ff;
  logic [7:0]                       rd_val;
  int                               err_total = 0;
  int                               cmp_count = 0;
  // write table, offsets 0x47..0x4c, high bytes carry junk above bit 2
  logic [7:0] wdat [6] = '{8'hfa, 8'ha5, 8'hf9, 8'h0f, 8'hfa, 8'hff};
  logic [7:0] rexp [6] = '{8'h02, 8'ha5, 8'h01, 8'h0f, 8'h02, 8'hff};

  // design under test
  window_geometry_registers dut_u (
    .clock     (clock),
    .reset_n   (reset_n),
    .req       (req),
    .rdata_ff  (rdata_ff),
    .rvalid_ff (rvalid_ff),
    .geom_ff   (geom_ff)
  );

  // free running clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // compare and count
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict and stop
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // one write over one rising edge; next call or idle replaces it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(negedge clock);
  endtask : wr

  // one read, data checked at the falling edge after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    check({11'h000, rvalid_ff}, 12'h001);
    d = rdata_ff;
  endtask : rd

  // bus idle for n cycles
  task automatic idle(input int n);
    req = '0;
    repeat (n) @(negedge clock);
  endtask : idle

  // main sequence
  initial begin
    req     = '0;
    reset_n = 1'b0;
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    repeat (2) @(negedge clock);
    check(geom_ff.row_count, 12'h001);
    check(geom_ff.col_count, 12'h001);
    for (int i = 0; i < 6; i++) begin
      rd(8'h47 + 8'(i), rd_val);
      check({4'h0, rd_val}, 12'h000);
    end
    // back to back writes of the whole bank, window inside the array
    for (int i = 0; i < 6; i++) wr(8'h47 + 8'(i), wdat[i]);
    wr(8'h46, 8'hff);
    idle(2);
    check({1'b0, geom_ff.row_depth}, 12'h2a5);
    check({1'b0, geom_ff.start_col}, 12'h10f);
    check({1'b0, geom_ff.col_width}, 12'h2ff);
    check(geom_ff.row_count, 12'h2a6);
    check(geom_ff.col_count, 12'h300);
    for (int i = 0; i < 6; i++) begin
      rd(8'h47 + 8'(i), rd_val);
      check({4'h0, rd_val}, {4'h0, rexp[i]});
    end
    rd(8'h4d, rd_val);
    check({4'h0, rd_val}, 12'h000);
    // write then read straight away of a high byte with junk bits
    wr(8'h47, 8'hfa);
    rd(8'h47, rd_val);
    check({4'h0, rd_val}, 12'h002);
    // widest window from column zero and a single row
    wr(8'h49, 8'hf8);
    wr(8'h4a, 8'h00);
    wr(8'h4b, 8'hfd);
    wr(8'h4c, 8'h0f);
    wr(8'h47, 8'hf8);
    wr(8'h48, 8'h00);
    idle(2);
    check(geom_ff.row_count, 12'h001);
    check(geom_ff.col_count, 12'h510);
    check({1'b0, geom_ff.row_depth}, 12'h000);
    check({1'b0, geom_ff.start_col}, 12'h000);
    end_of_test();
  end

  // watchdog
  initial begin
    #20us;
    err_total++;
    end_of_test();
  end
endmodule : tb_window_geometry_registers
